// ==== pkg/lbp_map.svh ====
// register offsets, field positions, reset values and timing counts of the breathing pwm core
`ifndef LBP_MAP_SVH
`define LBP_MAP_SVH

// ************************************************************
// register offsets (byte addresses on the bus)
// ************************************************************
`define LBP_OFF_CFG 8'h00
`define LBP_OFF_LIMITS 8'h04
`define LBP_OFF_DELAY 8'h08
`define LBP_OFF_STEP 8'h0C
`define LBP_OFF_INTERVAL 8'h10
`define LBP_OFF_STATUS 8'h18

// ************************************************************
// configuration field positions
// ************************************************************
`define LBP_CFG_CTRL_LSB 0
`define LBP_CFG_SRC_BIT 2
`define LBP_CFG_WIDTH_LSB 4
`define LBP_CFG_UPD_BIT 6
`define LBP_CFG_RST_BIT 7
`define LBP_CFG_WDT_LSB 8
`define LBP_CFG_ASYM_BIT 16

// ************************************************************
// reset values and writable masks
// ************************************************************
`define LBP_WDT_RELOAD_RST 8'h14
`define LBP_CFG_RST 32'h0000_1400
`define LBP_CFG_WMASK 32'h0001_FF77
`define LBP_LIMITS_WMASK 32'h0000_FFFF
`define LBP_DELAY_WMASK 32'h00FF_FFFF
`define LBP_FULL_WMASK 32'hFFFF_FFFF
`define LBP_DUTY_FULL 8'hFF

// ************************************************************
// timing: main clock and slow time-base rates
// ************************************************************
`define LBP_CLK_HZ 10000000
`define LBP_SLOW_HZ 32768
`define LBP_SLOW_DIV (`LBP_CLK_HZ / `LBP_SLOW_HZ)

`endif

// ==== pkg/lbp_pkg.sv ====
// types shared by the breathing pwm core files
package lbp_pkg;

	// ************************************************************
	// output mode field encoding
	// ************************************************************
	typedef enum logic [1:0] {
		LBP_CTRL_OFF = 2'b00,
		LBP_CTRL_BREATH = 2'b01,
		LBP_CTRL_BLINK = 2'b10,
		LBP_CTRL_ON = 2'b11
	} lbp_ctrl_t;

	// ************************************************************
	// breathing sequencer states
	// ************************************************************
	typedef enum logic [1:0] {
		LBP_ST_RISE = 2'b00,
		LBP_ST_HOLD_HI = 2'b01,
		LBP_ST_FALL = 2'b10,
		LBP_ST_HOLD_LO = 2'b11
	} lbp_breath_state_t;

endpackage : lbp_pkg

// ==== core/lbp_tick_div.sv ====
// divider making the slow time-base enable pulse from the main clock
`include "lbp_map.svh"

module lbp_tick_div #(
	parameter int unsigned DIV = `LBP_SLOW_DIV
) (
	input wire logic clk_i,
	input wire logic rst_i,
	output logic tick_o
);

	logic [15:0] cnt_reg; // cycles since last pulse
	logic [15:0] cnt_next;
	logic tick_reg; // one-cycle enable
	logic tick_next;

	// wrap at div-1 and pulse once per wrap
	always_comb begin
		tick_next = (cnt_reg == 16'(DIV - 1));
		cnt_next = tick_next ? 16'h0000 : cnt_reg + 16'h0001;
	end

	// registers only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= 16'h0000;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick_o = tick_reg;

endmodule : lbp_tick_div

// ==== core/lbp_watchdog.sv ====
// watchdog down counter that forces the output on when duty updates stop
`include "lbp_map.svh"

module lbp_watchdog (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic enable_i,
	input wire logic reload_i,
	input wire logic [7:0] reload_value_i,
	input wire logic tick_i,
	output logic [7:0] count_o,
	output logic timeout_o
);

	logic [7:0] count_reg; // remaining 200 ms units
	logic [7:0] count_next;
	logic timeout_reg; // one-cycle timeout pulse
	logic timeout_next;

	// reload beats decrement; a missing tick simply holds the count
	always_comb begin
		count_next = count_reg;
		timeout_next = 1'b0;
		if (reload_i) begin
			count_next = reload_value_i;
		end else if (enable_i && tick_i && (count_reg != 8'h00)) begin
			count_next = count_reg - 8'h01;
			timeout_next = (count_reg == 8'h01);
		end
	end

	// registers only; reset loads the documented reload default
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_reg <= `LBP_WDT_RELOAD_RST;
			timeout_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			timeout_reg <= timeout_next;
		end
	end

	assign count_o = count_reg;
	assign timeout_o = timeout_reg;

endmodule : lbp_watchdog

// ==== core/lbp_core.sv ====
// breathing / blinking pwm core with wishbone register slave and watchdog
// ************************************************************
// ************************************************************
`include "lbp_map.svh"

module lbp_core #(
	parameter int unsigned SLOW_DIV = `LBP_SLOW_DIV
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic tick_5hz_i,
	output logic led_o,
	output logic wdt_event_o
);

	// ************************************************************
	// helper functions
	// ************************************************************

	// byte-lane merge of a write into a register, reserved bits kept zero
	function automatic logic [31:0] lbp_merge(input logic [31:0] old_val,
		input logic [31:0] wdata, input logic [3:0] sel, input logic [31:0] mask);
		logic [31:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = wdata[b*8 +: 8];
			end
		end
		return res & mask;
	endfunction : lbp_merge

	// pick the 4-bit segment field for a segment index
	function automatic logic [3:0] lbp_nibble(input logic [31:0] word, input logic [2:0] idx);
		return word[{idx, 2'b00} +: 4];
	endfunction : lbp_nibble

	// top count of the breathing counter for a width selection
	function automatic logic [7:0] lbp_top(input logic [1:0] width);
		case (width)
			2'b01: return 8'h7F; // 7-bit
			2'b10: return 8'h3F; // 6-bit
			default: return 8'hFF; // 8-bit, reserved code treated the same
		endcase
	endfunction : lbp_top

	// ************************************************************
	// declarations
	// ************************************************************
	logic ack_reg; // bus answer
	logic ack_next;
	logic [31:0] rdata_reg; // read data stands with ack
	logic [31:0] rdata_next;
	logic [31:0] cfg_reg; // configuration register
	logic [31:0] cfg_next;
	logic [31:0] limits_reg; // ceiling and floor
	logic [31:0] limits_next;
	logic [31:0] delay_reg; // high hold and low delay
	logic [31:0] delay_next;
	logic [31:0] step_reg; // eight step sizes
	logic [31:0] step_next;
	logic [31:0] interval_reg; // eight update intervals
	logic [31:0] interval_next;
	logic [7:0] pwm_cnt_reg; // pwm cycle counter
	logic [7:0] pwm_cnt_next;
	logic [11:0] delay_cnt_reg; // prescaler, or hold counter while breathing
	logic [11:0] delay_cnt_next;
	logic [3:0] seg_cnt_reg; // periods since last duty update
	logic [3:0] seg_cnt_next;
	logic [7:0] duty_reg; // working duty while breathing
	logic [7:0] duty_next;
	lbp_pkg::lbp_breath_state_t bstate_reg;
	lbp_pkg::lbp_breath_state_t bstate_next;
	logic led_reg; // pin driver
	logic led_next;

	logic req; // bus request pending
	logic wr_commit; // write takes effect at this edge
	logic sel_cfg, sel_limits, sel_delay, sel_step, sel_interval, sel_status;
	logic soft_reset; // self-clearing reset bit written as one
	logic period_end; // breathing counter wraps this tick
	logic slow_tick; // slow time-base enable
	logic base_tick; // blink prescaler input enable
	logic gp_mode; // blinking on the main clock
	logic wdt_reload;
	logic wdt_timeout;
	logic [7:0] wdt_count;
	lbp_pkg::lbp_ctrl_t ctrl;
	logic [7:0] floor_val, ceil_val, top_val;
	logic [11:0] low_delay_count, high_hold_time;
	logic [2:0] seg_idx;
	logic [3:0] seg_step, seg_interval;
	logic [8:0] duty_up;
	logic [8:0] duty_dn;

	// ************************************************************
	// field views and address decode
	// ************************************************************
	assign ctrl = lbp_pkg::lbp_ctrl_t'(cfg_reg[`LBP_CFG_CTRL_LSB +: 2]);
	assign floor_val = limits_reg[7:0];
	assign ceil_val = limits_reg[15:8];
	assign low_delay_count = delay_reg[11:0];
	assign high_hold_time = delay_reg[23:12];
	assign top_val = lbp_top(cfg_reg[`LBP_CFG_WIDTH_LSB +: 2]);
	assign gp_mode = (ctrl == lbp_pkg::LBP_CTRL_BLINK) && cfg_reg[`LBP_CFG_SRC_BIT];
	assign req = wb_cyc_i && wb_stb_i;
	assign wr_commit = req && wb_we_i && ack_reg;
	assign sel_cfg = ({wb_adr_i[7:2], 2'b00} == `LBP_OFF_CFG);
	assign sel_limits = ({wb_adr_i[7:2], 2'b00} == `LBP_OFF_LIMITS);
	assign sel_delay = ({wb_adr_i[7:2], 2'b00} == `LBP_OFF_DELAY);
	assign sel_step = ({wb_adr_i[7:2], 2'b00} == `LBP_OFF_STEP);
	assign sel_interval = ({wb_adr_i[7:2], 2'b00} == `LBP_OFF_INTERVAL);
	assign sel_status = ({wb_adr_i[7:2], 2'b00} == `LBP_OFF_STATUS);
	assign soft_reset = wr_commit && sel_cfg && wb_sel_i[0] && wb_dat_i[`LBP_CFG_RST_BIT];
	// reload on any config write, or on a write that touches the floor byte
	assign wdt_reload = wr_commit && (sel_cfg || (sel_limits && wb_sel_i[0]));

	// ************************************************************
	// submodules
	// ************************************************************

	// slow time base, stands in for the 32.768 kHz clock
	lbp_tick_div #(
		.DIV(SLOW_DIV)
	) u_slow_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_o(slow_tick)
	);

	// watchdog; reload value is the field as it stands after the write
	lbp_watchdog u_wdt (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.enable_i(gp_mode),
		.reload_i(wdt_reload),
		.reload_value_i(cfg_next[`LBP_CFG_WDT_LSB +: 8]),
		.tick_i(tick_5hz_i),
		.count_o(wdt_count),
		.timeout_o(wdt_timeout)
	);

	// ************************************************************
	// wishbone slave: one wait state, ack for one cycle
	// ************************************************************

	// unmapped offsets still answer, read as zero and drop writes
	always_comb begin
		ack_next = req && !ack_reg;
		rdata_next = rdata_reg;
		if (req && !ack_reg) begin
			rdata_next = 32'h0000_0000;
			if (sel_cfg) begin
				rdata_next = cfg_reg; // reset bit is never stored, reads zero
			end else if (sel_limits) begin
				rdata_next = limits_reg;
			end else if (sel_delay) begin
				rdata_next = delay_reg;
			end else if (sel_step) begin
				rdata_next = step_reg;
			end else if (sel_interval) begin
				rdata_next = interval_reg;
			end else if (sel_status) begin
				rdata_next = {6'h00, bstate_reg, wdt_count, pwm_cnt_reg, duty_reg};
			end
		end
	end

	// bus registers only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
		end
	end

	// ************************************************************
	// software registers
	// ************************************************************

	// writes land at the ack edge; hardware set of the mode wins over software
	always_comb begin
		cfg_next = cfg_reg;
		limits_next = limits_reg;
		delay_next = delay_reg;
		step_next = step_reg;
		interval_next = interval_reg;
		if (wr_commit) begin
			if (sel_cfg) begin
				cfg_next = lbp_merge(cfg_reg, wb_dat_i, wb_sel_i, `LBP_CFG_WMASK);
				// update flag is write-one-to-set only
				cfg_next[`LBP_CFG_UPD_BIT] = cfg_reg[`LBP_CFG_UPD_BIT] ||
					(wb_sel_i[0] && wb_dat_i[`LBP_CFG_UPD_BIT]);
			end
			if (sel_limits) begin
				limits_next = lbp_merge(limits_reg, wb_dat_i, wb_sel_i, `LBP_LIMITS_WMASK);
			end
			if (sel_delay) begin
				delay_next = lbp_merge(delay_reg, wb_dat_i, wb_sel_i, `LBP_DELAY_WMASK);
			end
			if (sel_step) begin
				step_next = lbp_merge(step_reg, wb_dat_i, wb_sel_i, `LBP_FULL_WMASK);
			end
			if (sel_interval) begin
				interval_next = lbp_merge(interval_reg, wb_dat_i, wb_sel_i, `LBP_FULL_WMASK);
			end
		end
		// period end counts as the operating copy, so the flag drops unless set now
		if (period_end && !(wr_commit && sel_cfg && wb_sel_i[0] && wb_dat_i[`LBP_CFG_UPD_BIT])) begin
			cfg_next[`LBP_CFG_UPD_BIT] = 1'b0;
		end
		if (soft_reset) begin
			cfg_next = `LBP_CFG_RST;
			limits_next = 32'h0000_0000;
			delay_next = 32'h0000_0000;
			step_next = 32'h0000_0000;
			interval_next = 32'h0000_0000;
		end
		if (wdt_timeout) begin
			cfg_next[`LBP_CFG_CTRL_LSB +: 2] = lbp_pkg::LBP_CTRL_ON;
		end
	end

	// register file flops only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_reg <= `LBP_CFG_RST;
			limits_reg <= 32'h0000_0000;
			delay_reg <= 32'h0000_0000;
			step_reg <= 32'h0000_0000;
			interval_reg <= 32'h0000_0000;
		end else begin
			cfg_reg <= cfg_next;
			limits_reg <= limits_next;
			delay_reg <= delay_next;
			step_reg <= step_next;
			interval_reg <= interval_next;
		end
	end

	// ************************************************************
	// pwm engine: counters, breathing sequencer, output
	// ************************************************************

	// falling ramps index the upper four segments in asymmetric mode
	assign seg_idx = cfg_reg[`LBP_CFG_ASYM_BIT] ?
		{(bstate_reg == lbp_pkg::LBP_ST_FALL), duty_reg[7:6]} :
		duty_reg[7:5];
	assign seg_step = lbp_nibble(step_reg, seg_idx);
	assign seg_interval = lbp_nibble(interval_reg, seg_idx);
	assign duty_up = {1'b0, duty_reg} + {5'h00, seg_step};
	assign duty_dn = {1'b0, duty_reg} - {5'h00, seg_step};
	assign period_end = (ctrl == lbp_pkg::LBP_CTRL_BREATH) && slow_tick && (pwm_cnt_reg == top_val);
	// blink prescaler input: every cycle on the main clock, else the slow tick
	assign base_tick = cfg_reg[`LBP_CFG_SRC_BIT] ? 1'b1 : slow_tick;

	// next state of counters, duty, sequencer and output
	always_comb begin
		pwm_cnt_next = pwm_cnt_reg;
		delay_cnt_next = delay_cnt_reg;
		seg_cnt_next = seg_cnt_reg;
		duty_next = duty_reg;
		bstate_next = bstate_reg;
		led_next = 1'b0;
		case (ctrl)
			lbp_pkg::LBP_CTRL_OFF: begin
				pwm_cnt_next = 8'h00;
				delay_cnt_next = 12'h000;
				seg_cnt_next = 4'h0;
				duty_next = 8'h00;
				bstate_next = lbp_pkg::LBP_ST_RISE;
				led_next = 1'b0;
			end
			lbp_pkg::LBP_CTRL_BREATH: begin
				if (slow_tick) begin
					// wrap at the width-selected top
					pwm_cnt_next = period_end ? 8'h00 : pwm_cnt_reg + 8'h01;
				end
				if (period_end) begin
					case (bstate_reg)
						lbp_pkg::LBP_ST_RISE: begin
							if (seg_cnt_reg < seg_interval) begin
								seg_cnt_next = seg_cnt_reg + 4'h1;
							end else begin
								seg_cnt_next = 4'h0;
								if (duty_up >= {1'b0, ceil_val}) begin
									duty_next = ceil_val;
									delay_cnt_next = high_hold_time;
									bstate_next = lbp_pkg::LBP_ST_HOLD_HI;
								end else begin
									duty_next = duty_up[7:0];
								end
							end
						end
						lbp_pkg::LBP_ST_HOLD_HI: begin
							if (delay_cnt_reg == 12'h000) begin
								bstate_next = lbp_pkg::LBP_ST_FALL;
							end else begin
								delay_cnt_next = delay_cnt_reg - 12'h001;
							end
						end
						lbp_pkg::LBP_ST_FALL: begin
							if (seg_cnt_reg < seg_interval) begin
								seg_cnt_next = seg_cnt_reg + 4'h1;
							end else begin
								seg_cnt_next = 4'h0;
								// borrow means the step passed zero, so below the floor too
								if (duty_dn[8] || (duty_dn[7:0] <= floor_val)) begin
									duty_next = floor_val;
									delay_cnt_next = low_delay_count;
									bstate_next = lbp_pkg::LBP_ST_HOLD_LO;
								end else begin
									duty_next = duty_dn[7:0];
								end
							end
						end
						lbp_pkg::LBP_ST_HOLD_LO: begin
							if (delay_cnt_reg == 12'h000) begin
								bstate_next = lbp_pkg::LBP_ST_RISE;
							end else begin
								delay_cnt_next = delay_cnt_reg - 12'h001;
							end
						end
						default: begin
							bstate_next = lbp_pkg::LBP_ST_RISE;
						end
					endcase
				end
				led_next = (pwm_cnt_reg < duty_reg);
			end
			lbp_pkg::LBP_CTRL_BLINK: begin
				// only low delay, floor and config steer this path
				if (base_tick) begin
					if (delay_cnt_reg == 12'h000) begin
						// zero reload gives one count per input tick
						delay_cnt_next = low_delay_count;
						pwm_cnt_next = pwm_cnt_reg + 8'h01;
					end else begin
						delay_cnt_next = delay_cnt_reg - 12'h001;
					end
				end
				// full-scale duty keeps the pin on through count FFh
				led_next = (floor_val == `LBP_DUTY_FULL) || (pwm_cnt_reg < floor_val);
			end
			lbp_pkg::LBP_CTRL_ON: begin
				led_next = 1'b1;
			end
			default: begin
				led_next = 1'b0;
			end
		endcase
		if (soft_reset) begin
			pwm_cnt_next = 8'h00;
			delay_cnt_next = 12'h000;
			seg_cnt_next = 4'h0;
			duty_next = 8'h00;
			bstate_next = lbp_pkg::LBP_ST_RISE;
		end
	end

	// engine flops only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pwm_cnt_reg <= 8'h00;
			delay_cnt_reg <= 12'h000;
			seg_cnt_reg <= 4'h0;
			duty_reg <= 8'h00;
			bstate_reg <= lbp_pkg::LBP_ST_RISE;
			led_reg <= 1'b0;
		end else begin
			pwm_cnt_reg <= pwm_cnt_next;
			delay_cnt_reg <= delay_cnt_next;
			seg_cnt_reg <= seg_cnt_next;
			duty_reg <= duty_next;
			bstate_reg <= bstate_next;
			led_reg <= led_next;
		end
	end

	// ************************************************************
	// outputs, all from flops
	// ************************************************************
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;
	assign led_o = led_reg;
	assign wdt_event_o = wdt_timeout;

endmodule : lbp_core

// ==== dv/lbp_core_sva.sv ====
// checker for the breathing pwm core ports
module lbp_core_sva #(
	parameter int unsigned SLOW_DIV = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic tick_5hz_i,
	input wire logic led_o,
	input wire logic wdt_event_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ************************************************************
	// shadow of mode, source and duty floor
	// ************************************************************
	logic [1:0] mode_reg, mode_next; // output mode as software sees it
	logic src_reg, src_next; // clock source bit
	logic [7:0] floor_reg, floor_next; // blink duty
	logic [1:0] quiet_reg, quiet_next; // cycles since last change, saturates
	logic wr_cfg, wr_lim; // accepted writes
	assign wr_cfg = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i[7:2] == 6'h00;
	assign wr_lim = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i[7:2] == 6'h01;
	// next shadow values; the timeout wins over a same-cycle write
	always_comb begin
		mode_next = mode_reg;
		src_next = src_reg;
		floor_next = floor_reg;
		quiet_next = (quiet_reg == 2'h3) ? quiet_reg : quiet_reg + 2'h1;
		if (wr_cfg && wb_sel_i[0]) begin
			mode_next = wb_dat_i[1:0];
			src_next = wb_dat_i[2];
			quiet_next = 2'h0;
			if (wb_dat_i[7]) begin // soft reset clears all
				mode_next = 2'h0;
				src_next = 1'b0;
				floor_next = 8'h00;
			end
		end
		if (wr_lim && wb_sel_i[0]) begin
			floor_next = wb_dat_i[7:0];
			quiet_next = 2'h0;
		end
		if (wdt_event_o) begin
			mode_next = 2'h3;
			quiet_next = 2'h0;
		end
		if (rst_i) begin
			mode_next = 2'h0;
			src_next = 1'b0;
			floor_next = 8'h00;
			quiet_next = 2'h0;
		end
	end
	// registers only
	always_ff @(posedge clk_i) begin
		mode_reg <= mode_next;
		src_reg <= src_next;
		floor_reg <= floor_next;
		quiet_reg <= quiet_next;
	end
	// ************************************************************
	// properties
	// ************************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_lit;
		##[1:3] led_o;
	endsequence
	ack_follow_a: assert property (s_req |=> wb_ack_o)
		else $error("ack missing after request");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i) && !$past(wb_ack_o))
		else $error("ack without request");
	reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !led_o && !wdt_event_o)
		else $error("outputs active after reset");
	wdt_pulse_a: assert property (wdt_event_o |=> !wdt_event_o)
		else $error("timeout event longer than one cycle");
	wdt_tick_a: assert property (wdt_event_o |-> $past(tick_5hz_i))
		else $error("timeout without tick");
	wdt_mode_a: assert property (wdt_event_o |-> $past(mode_reg) == 2'h2 && $past(src_reg))
		else $error("timeout outside general purpose mode");
	wdt_force_a: assert property (wdt_event_o |-> s_lit)
		else $error("timeout did not force output on");
	on_force_a: assert property (mode_reg == 2'h3 && quiet_reg == 2'h3 |-> led_o)
		else $error("on mode output low");
	off_dark_a: assert property (mode_reg == 2'h0 && quiet_reg == 2'h3 |-> !led_o)
		else $error("off mode output high");
	blink_dark_a: assert property (mode_reg == 2'h2 && quiet_reg == 2'h3 && floor_reg == 8'h00 |-> !led_o)
		else $error("zero duty output high");
	blink_full_a: assert property (mode_reg == 2'h2 && quiet_reg == 2'h3 && floor_reg == 8'hFF |-> led_o)
		else $error("full duty output low");
endmodule : lbp_core_sva

bind lbp_core lbp_core_sva #(.SLOW_DIV(SLOW_DIV)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.tick_5hz_i(tick_5hz_i), .led_o(led_o), .wdt_event_o(wdt_event_o));

// ==== dv/lbp_led_load.sv ====
// load model: counts on cycles and switch-on pulses of the led drive
module lbp_led_load (
	input wire logic clk_i,
	input wire logic led_i,
	output int on_cycles_o,
	output int pulses_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic last_reg; // previous drive level, for edge counting
	initial begin
		on_cycles_o = 0;
		pulses_o = 0;
		last_reg = 1'b0;
	end
	// an unknown drive counts as off, so it cannot pass for on
	always @(posedge clk_i) begin
		on_cycles_o <= on_cycles_o + int'(led_i === 1'b1);
		pulses_o <= pulses_o + int'(led_i === 1'b1 && last_reg !== 1'b1);
		last_reg <= led_i;
	end
endmodule : lbp_led_load

// ==== dv/testbench.sv ====
// self-checking bench for the breathing pwm core
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic tick_5hz_i = 1'b0, wb_ack_o, led_o, wdt_event_o;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
	int miscompares = 0, n_tests = 0, cycles = 0, n_evt = 0, on_cnt, pul_cnt, on0, pul0, maxc;
	bit hi_seen, lo_seen;
	logic [31:0] ld_t[4] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0001};
	logic [7:0] fl_t[4] = '{8'h00, 8'hFF, 8'h40, 8'h80};
	int on_t[4] = '{0, 1024, 256, 512};
	int pu_t[4] = '{0, 0, 4, 2};
	always #50 clk_i = ~clk_i;
	lbp_core #(.SLOW_DIV(4)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.tick_5hz_i(tick_5hz_i), .led_o(led_o), .wdt_event_o(wdt_event_o));
	lbp_led_load u_load (.clk_i(clk_i), .led_i(led_o), .on_cycles_o(on_cnt), .pulses_o(pul_cnt));
	// cycle ceiling and timeout event count
	always @(posedge clk_i) begin
		cycles++;
		n_evt += int'(wdt_event_o === 1'b1);
		if (cycles == 40000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	task tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t word %h want %h", $time, got, exp);
		end
	endtask : chk_word
	task chk_num(input int got, input int exp);
		n_tests++;
		if (got != exp) begin
			miscompares++;
			$display("BAD %0t count %0d want %0d", $time, got, exp);
		end
	endtask : chk_num
	// one classic cycle: hold until ack is sampled, then release
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			miscompares++;
			$display("BAD %0t no ack at address %h", $time, a);
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	task rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		wb(1'b0, a, 32'h0000_0000, 4'hF);
		chk_word(rd & m, exp);
	endtask : rdm
	task tick(input int n);
		repeat (n) begin
			@(posedge clk_i);
			tick_5hz_i <= 1'b1;
			@(posedge clk_i);
			tick_5hz_i <= 1'b0;
		end
	endtask : tick
	// settle, then count over 1024 clocks
	task measure(input int on_exp, input int pu_exp);
		repeat (600) @(posedge clk_i);
		on0 = on_cnt;
		pul0 = pul_cnt;
		repeat (1024) @(posedge clk_i);
		chk_num(on_cnt - on0, on_exp);
		chk_num(pul_cnt - pul0, pu_exp);
	endtask : measure
	// breathing run polling the status word
	task breathe(input logic [31:0] cfg, input int n);
		wb(1'b1, 8'h00, 32'h0000_0080, 4'hF);
		wb(1'b1, 8'h04, 32'h0000_4000, 4'hF);
		wb(1'b1, 8'h08, 32'h0000_1001, 4'hF);
		wb(1'b1, 8'h0C, 32'h0000_0888, 4'hF);
		wb(1'b1, 8'h00, cfg, 4'hF);
		maxc = 0;
		hi_seen = 1'b0;
		lo_seen = 1'b0;
		repeat (n) begin
			wb(1'b0, 8'h18, 32'h0000_0000, 4'hF);
			if (int'(rd[15:8]) > maxc)
				maxc = int'(rd[15:8]);
			if (rd[25:24] === 2'h1 && rd[7:0] === 8'h40)
				hi_seen = 1'b1;
			if (rd[25:24] === 2'h3)
				lo_seen = 1'b1;
		end
	endtask : breathe
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rdm(8'h00, 32'hFFFF_FFFF, 32'h0000_1400);
		rdm(8'h18, 32'hFFFF_FFFF, 32'h0014_0000);
		rdm(8'h14, 32'hFFFF_FFFF, 32'h0000_0000);
		wb(1'b1, 8'h00, 32'hFFFF_FF7C, 4'hF);
		rdm(8'h00, 32'hFFFF_FFFF, 32'h0001_FF74);
		wb(1'b1, 8'h04, 32'h0000_A55A, 4'hF);
		rdm(8'h04, 32'hFFFF_FFFF, 32'h0000_A55A);
		wb(1'b1, 8'h00, 32'h0000_0080, 4'h1);
		rdm(8'h00, 32'hFFFF_FFFF, 32'h0000_1400);
		rdm(8'h04, 32'hFFFF_FFFF, 32'h0000_0000);
		// blink with width, asymmetry and a step table that must not matter
		wb(1'b1, 8'h0C, 32'hFFFF_FFFF, 4'hF);
		wb(1'b1, 8'h00, 32'h0001_0026, 4'hF);
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, 8'h08, ld_t[i], 4'hF);
			wb(1'b1, 8'h04, {24'h00_0000, fl_t[i]}, 4'h1);
			measure(on_t[i], pu_t[i]);
		end
		for (int w = 0; w < 2; w++) begin
			breathe(32'h0000_0001 | (w << 4), 400);
			chk_num(maxc, 255 >> w);
		end
		breathe(32'h0000_0021, 2000);
		chk_num(maxc, 63);
		chk_num(hi_seen + 2 * lo_seen, 3);
		breathe(32'h0001_0021, 2000);
		chk_num(hi_seen + 2 * lo_seen, 1);
		// watchdog
		wb(1'b1, 8'h00, 32'h0000_0306, 4'hF);
		rdm(8'h18, 32'h00FF_0000, 32'h0003_0000);
		tick(2);
		rdm(8'h18, 32'h00FF_0000, 32'h0001_0000);
		repeat (50) @(posedge clk_i);
		rdm(8'h18, 32'h00FF_0000, 32'h0001_0000);
		wb(1'b1, 8'h04, 32'h0000_0000, 4'h1);
		rdm(8'h18, 32'h00FF_0000, 32'h0003_0000);
		wb(1'b1, 8'h00, 32'h0000_0302, 4'hF);
		tick(2);
		rdm(8'h18, 32'h00FF_0000, 32'h0003_0000);
		wb(1'b1, 8'h00, 32'h0000_0306, 4'hF);
		tick(3);
		repeat (4) @(posedge clk_i);
		chk_num(n_evt, 1);
		rdm(8'h00, 32'hFFFF_FFFF, 32'h0000_0307);
		chk_word({31'h0000_0000, led_o}, 32'h0000_0001);
		wb(1'b1, 8'h00, 32'h0000_0006, 4'hF);
		tick(2);
		rdm(8'h18, 32'h00FF_0000, 32'h0000_0000);
		chk_num(n_evt, 1);
		tally_and_finish();
	end
endmodule : testbench
